// [hw/sector_seq_pkg.sv]
// constants, enums and register map of the sector read sequencer
// Overview of operation
// - header done while reading enters sequence 6
// - sequence 6 skips two sync bytes, crystal clock
// - two skipped bytes give terminal count, sequence 4
// - sequence 4 raises read gate, recovered clock
// - count-run low in sequence 4 clears deserializer
// - read bit XOR deserializer output detects sync
// - detect high in sequence 4 enters sequence 5
// - sequence 5 gate follows direction: read or write
// - count-run high in sequence 5 gives byte ticks
// - read bits shift into deserializer on bit clock
// - phase 0 drives shifter onto byte bus
// - phase 0 loads holding register from byte bus
// - ram input select routes holding byte to RAM
// - one sequence strobe per byte at phase 1
// - strobe in sequence 5 writes RAM, then address increments
// - counters reset to 553, 555, 19 less the 18 header-check decrements
// - counters decrement on strobe while count-run high
// - crc start counter zero releases CRC checker
// - CRC mismatch sets sticky active-low fail flag
// - data length expiry freezes CRC, enters sequence 2
// - settle zero in sequence 2 pulses sector finished
// - start low returns sequencer to sequence 0
package sector_seq_pkg;
  typedef enum logic [7:0]
  {
    SEQ0 = 8'h01, SEQ1 = 8'h02, SEQ2 = 8'h04, SEQ3 = 8'h08,
    SEQ4 = 8'h10, SEQ5 = 8'h20, SEQ6 = 8'h40, SEQ7 = 8'h80
  } seq_e;

  // ----------------------------------------------------------------
  // counter loads and the amounts the header check already consumed
  // ----------------------------------------------------------------
  localparam int LEN_LOAD    = 553;
  localparam int SETTLE_LOAD = 555;
  localparam int CRCST_LOAD  = 19;
  localparam int SEQ1_DEC    = 2;
  localparam int SEQ7_DEC    = 16;
  localparam int HDR_DEC     = SEQ1_DEC + SEQ7_DEC;
  localparam int SKIP_BYTES  = 2;
  localparam int BYTE_BITS   = 8;
  localparam int SKIP_BITS   = SKIP_BYTES * BYTE_BITS;
  localparam int XTAL_DIV    = 4;

  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_LEN    = 8'h04;
  localparam logic [7:0] ADDR_SETTLE = 8'h08;
  localparam logic [7:0] ADDR_CRCST  = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_MADDR  = 8'h14;
  localparam logic [7:0] ADDR_SWDATA = 8'h18;

  localparam int CTRL_START = 0;
  localparam int CTRL_DIR   = 1;
  localparam int CTRL_MSEL  = 2;
  localparam int ST_FAIL    = 8;
  localparam int ST_CRCREL  = 9;
  localparam int ST_DONE    = 10;
  localparam int ST_RDGATE  = 11;
  localparam int ST_WRGATE  = 12;

  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'h0000;
endpackage

// [hw/level_sync.sv]
// two-flop synchroniser with rising-edge output
`timescale 1ns/10ps
`default_nettype none
module level_sync
(
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_ce,
  input  wire logic i_async,
  output logic      o_level,
  output logic      o_rise
);
  typedef struct packed
  {
    logic s1;
    logic s2;
    logic s3;
  } state_s;

  state_s r_reg;
  state_s r_next;

  always_comb
  begin
    r_next    = r_reg;
    r_next.s1 = i_async;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      r_reg <= '0;
    else if (i_ce)
      r_reg <= r_next;
  end

  // edge detect looks only at the second and third stages
  assign o_level = r_reg.s2;
  assign o_rise  = r_reg.s2 & ~r_reg.s3;
endmodule // level_sync
`default_nettype wire

// [hw/crc_checker.sv]
// serial CRC checker with freeze and sticky fail flag
`timescale 1ns/10ps
`default_nettype none
module crc_checker
  import sector_seq_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_ce,
  input  wire logic i_release,
  input  wire logic i_freeze,
  input  wire logic i_bit_en,
  input  wire logic i_bit,
  input  wire logic i_clear,
  output logic      o_fail_n
);
  typedef struct packed
  {
    logic [15:0] crc;
    logic        frozen;
    logic        fail;
  } state_s;

  state_s r_reg;
  state_s r_next;
  logic   fb;

  always_comb
  begin
    r_next = r_reg;
    fb     = r_reg.crc[15] ^ i_bit;
    if (i_clear)
      r_next.fail = 1'b0;
    if (!i_release)
    begin
      r_next.crc    = CRC_INIT;
      r_next.frozen = 1'b0;
    end
    else if (i_freeze)
    begin
      // a nonzero remainder over data plus check bytes is a mismatch
      r_next.frozen = 1'b1;
      if (!r_reg.frozen && r_reg.crc != 16'h0000)
        r_next.fail = 1'b1;
    end
    else if (i_bit_en && !r_reg.frozen)
      r_next.crc = {r_reg.crc[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      r_reg <= '0;
    else if (i_ce)
      r_reg <= r_next;
  end

  assign o_fail_n = ~r_reg.fail;
endmodule // crc_checker
`default_nettype wire

// [hw/sector_read_seq.sv]
// read/write control sequencer: data field of a sector read
`timescale 1ns/10ps
`default_nettype none
module sector_read_seq
  import sector_seq_pkg::*;
#(
  parameter int CNT_W = 10,
  parameter int XDIV  = sector_seq_pkg::XTAL_DIV
)
(
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  // avalon-mm slave
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // read channel
  input  wire logic        i_recovered_bit_clock,
  input  wire logic        i_serial_read_bits,
  output logic             o_read_gate,
  output logic             o_write_gate,
  output logic             o_bitclk_recovered,
  // surrounding controller logic
  input  wire logic        i_header_done_addr_bit,
  output logic             o_count_run,
  output logic             o_byte_tick,
  output logic             o_terminal_count,
  output logic             o_shifter_output_enable,
  output logic [7:0]       o_byte_bus,
  output logic             o_holding_reg_load,
  output logic             o_sequence_strobe,
  output logic             o_crc_release,
  output logic             o_check_fail_flag_n,
  output logic             o_sector_finished,
  // buffer ram
  output logic [15:0]      o_mem_addr,
  output logic [7:0]       o_mem_wdata,
  output logic             o_mem_store_n
);
  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

  typedef struct packed
  {
    seq_e             seq;
    logic [2:0]       phase;
    logic [4:0]       skip;
    logic [3:0]       xdiv;
    logic [7:0]       shreg;
    logic [7:0]       hold;
    logic             got_byte;
    logic             load_p;
    logic             tc_p;
    logic             sf_p;
    logic             sf_done;
    logic             store_n;
    logic             hdr_q;
    logic [15:0]      addr;
    logic [7:0]       wdata;
    logic [7:0]       swdata;
    logic [CNT_W-1:0] len;
    logic [CNT_W-1:0] settle;
    logic [CNT_W-1:0] crcst;
    logic             start;
    logic             dir;
    logic             msel;
    logic             ack;
    logic [31:0]      rdata;
  } state_s;

  state_s r_reg;
  state_s r_next;

  logic rec_rise;
  logic bit_lvl;
  logic rd_gate;
  logic wr_gate;
  logic count_run;
  logic xtal_tick;
  logic bit_edge;
  logic data_det;
  logic byte_tick;
  logic strobe;
  logic sync_skip;
  logic hdr_rise;
  logic crc_rel;
  logic len_zero;
  logic req;
  logic wr_take;
  logic [31:0] status;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (be[i])
        res[8*i +: 8] = new_v[8*i +: 8];
    return res;
  endfunction

  // --------------------------------------------------------------
  // pin inputs from the channel
  // --------------------------------------------------------------
  level_sync u_clk_sync
  (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_ce    (i_ce),
    .i_async (i_recovered_bit_clock),
    .o_level (),
    .o_rise  (rec_rise)
  );

  level_sync u_bit_sync
  (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_ce    (i_ce),
    .i_async (i_serial_read_bits),
    .o_level (bit_lvl),
    .o_rise  ()
  );

  // --------------------------------------------------------------
  // gates, bit clock selection and byte timing
  // --------------------------------------------------------------
  assign rd_gate   = (r_reg.seq == SEQ4) | ((r_reg.seq == SEQ5) & r_reg.dir);
  assign wr_gate   = (r_reg.seq == SEQ5) & ~r_reg.dir;
  assign count_run = (r_reg.seq == SEQ5) | (r_reg.seq == SEQ2);
  assign xtal_tick = (r_reg.xdiv == 4'(XDIV - 1));
  assign bit_edge  = rd_gate ? rec_rise : xtal_tick;
  assign data_det  = bit_lvl ^ r_reg.shreg[7];
  assign byte_tick = count_run & bit_edge & (r_reg.phase == 3'h7);
  assign strobe    = count_run & bit_edge & (r_reg.phase == 3'h1) & r_reg.got_byte;
  assign sync_skip = (r_reg.skip == 5'(SKIP_BITS));
  assign hdr_rise  = i_header_done_addr_bit & ~r_reg.hdr_q;
  assign crc_rel   = (r_reg.crcst == '0);
  assign len_zero  = (r_reg.len == '0);
  assign req       = i_avs_read | i_avs_write;
  assign wr_take   = i_avs_write & r_reg.ack;

  always_comb
  begin
    status            = 32'h0000_0000;
    status[7:0]       = r_reg.seq;
    status[ST_FAIL]   = ~o_check_fail_flag_n;
    status[ST_CRCREL] = crc_rel;
    status[ST_DONE]   = r_reg.sf_done;
    status[ST_RDGATE] = rd_gate;
    status[ST_WRGATE] = wr_gate;
  end

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb
  begin
    r_next         = r_reg;
    r_next.tc_p    = 1'b0;
    r_next.sf_p    = 1'b0;
    r_next.load_p  = byte_tick;
    r_next.store_n = ~(strobe & (r_reg.seq == SEQ5));
    r_next.hdr_q   = i_header_done_addr_bit;
    r_next.xdiv    = xtal_tick ? 4'h0 : r_reg.xdiv + 4'h1;
    r_next.wdata   = r_reg.msel ? r_reg.hold : r_reg.swdata;

    // deserializer held clear until count-run rises
    if (!count_run)
    begin
      r_next.shreg    = 8'h00;
      r_next.phase    = 3'h0;
      r_next.got_byte = 1'b0;
    end
    else if (bit_edge)
    begin
      r_next.shreg = {r_reg.shreg[6:0], bit_lvl};
      r_next.phase = r_reg.phase + 3'h1;
    end

    if (r_reg.load_p)
    begin
      r_next.hold     = r_reg.shreg;
      r_next.got_byte = 1'b1;
    end
    else if (strobe)
      r_next.got_byte = 1'b0;

    if (!r_reg.store_n)
      r_next.addr = r_reg.addr + 16'h1;

    if (strobe)
    begin
      r_next.len    = len_zero ? r_reg.len : r_reg.len - ONE;
      r_next.settle = (r_reg.settle == '0) ? r_reg.settle : r_reg.settle - ONE;
      r_next.crcst  = crc_rel ? r_reg.crcst : r_reg.crcst - ONE;
    end

    case (r_reg.seq)
      SEQ0:
      begin
        r_next.sf_done = 1'b0;
        r_next.skip    = 5'h00;
        if (r_reg.start)
          r_next.seq = SEQ7;
      end
      SEQ7:
      begin
        if (hdr_rise)
          r_next.seq = r_reg.dir ? SEQ6 : SEQ5;
      end
      SEQ6:
      begin
        // first two sync bytes are unreliable, wait them out
        if (sync_skip)
        begin
          r_next.tc_p = 1'b1;
          r_next.seq  = SEQ4;
        end
        else if (xtal_tick)
          r_next.skip = r_reg.skip + 5'h01;
      end
      SEQ4:
      begin
        if (bit_edge && data_det)
          r_next.seq = SEQ5;
      end
      SEQ5:
      begin
        if (len_zero)
        begin
          r_next.tc_p = 1'b1;
          r_next.seq  = SEQ2;
        end
      end
      SEQ2:
      begin
        if (r_reg.settle == '0 && !r_reg.sf_done)
        begin
          r_next.sf_p    = 1'b1;
          r_next.sf_done = 1'b1;
          r_next.len     = '0;
          r_next.crcst   = '0;
        end
      end
      default:
        r_next.seq = SEQ0;
    endcase

    if (!r_reg.start)
      r_next.seq = SEQ0;

    // bus slave: one wait state, data and writes at the release edge
    r_next.ack   = req & ~r_reg.ack;
    r_next.rdata = 32'h0000_0000;
    if (i_avs_read && !r_reg.ack)
    begin
      case (i_avs_address)
        ADDR_CTRL:   r_next.rdata = {29'h0, r_reg.msel, r_reg.dir, r_reg.start};
        ADDR_LEN:    r_next.rdata = 32'(r_reg.len);
        ADDR_SETTLE: r_next.rdata = 32'(r_reg.settle);
        ADDR_CRCST:  r_next.rdata = 32'(r_reg.crcst);
        ADDR_STATUS: r_next.rdata = status;
        ADDR_MADDR:  r_next.rdata = {16'h0000, r_reg.addr};
        ADDR_SWDATA: r_next.rdata = {24'h000000, r_reg.swdata};
        default:     r_next.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_take)
    begin
      case (i_avs_address)
        ADDR_CTRL:
        begin
          if (i_avs_byteenable[0])
          begin
            r_next.start = i_avs_writedata[CTRL_START];
            r_next.dir   = i_avs_writedata[CTRL_DIR];
            r_next.msel  = i_avs_writedata[CTRL_MSEL];
          end
        end
        ADDR_LEN:
          r_next.len = CNT_W'(be_merge(32'(r_reg.len), i_avs_writedata,
                                       i_avs_byteenable));
        ADDR_SETTLE:
          r_next.settle = CNT_W'(be_merge(32'(r_reg.settle), i_avs_writedata,
                                          i_avs_byteenable));
        ADDR_CRCST:
          r_next.crcst = CNT_W'(be_merge(32'(r_reg.crcst), i_avs_writedata,
                                         i_avs_byteenable));
        ADDR_MADDR:
          r_next.addr = 16'(be_merge({16'h0000, r_reg.addr}, i_avs_writedata,
                                     i_avs_byteenable));
        ADDR_SWDATA:
          if (i_avs_byteenable[0])
            r_next.swdata = i_avs_writedata[7:0];
        default:
          r_next.swdata = r_reg.swdata;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      r_reg         <= '0;
      r_reg.seq     <= SEQ0;
      r_reg.store_n <= 1'b1;
      r_reg.dir     <= 1'b1;
      r_reg.len     <= CNT_W'(LEN_LOAD - HDR_DEC);
      r_reg.settle  <= CNT_W'(SETTLE_LOAD - HDR_DEC);
      r_reg.crcst   <= CNT_W'(CRCST_LOAD - HDR_DEC);
    end
    else if (i_ce)
      r_reg <= r_next;
  end

  // --------------------------------------------------------------
  // crc checker
  // --------------------------------------------------------------
  crc_checker u_crc
  (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_release (crc_rel & (r_reg.seq == SEQ5 || r_reg.seq == SEQ2)),
    .i_freeze  (len_zero),
    .i_bit_en  (bit_edge & (r_reg.seq == SEQ5)),
    .i_bit     (bit_lvl),
    .i_clear   (~r_reg.start),
    .o_fail_n  (o_check_fail_flag_n)
  );

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign o_avs_waitrequest       = req & ~r_reg.ack;
  assign o_avs_readdata          = r_reg.rdata;
  assign o_read_gate             = rd_gate;
  assign o_write_gate            = wr_gate;
  assign o_bitclk_recovered      = rd_gate;
  assign o_count_run             = count_run;
  assign o_byte_tick             = byte_tick;
  assign o_terminal_count        = r_reg.tc_p;
  assign o_shifter_output_enable = r_reg.load_p;
  assign o_byte_bus              = r_reg.load_p ? r_reg.shreg : 8'h00;
  assign o_holding_reg_load      = r_reg.load_p;
  assign o_sequence_strobe       = strobe;
  assign o_crc_release           = crc_rel;
  assign o_sector_finished       = r_reg.sf_p;
  assign o_mem_addr              = r_reg.addr;
  assign o_mem_wdata             = r_reg.wdata;
  assign o_mem_store_n           = r_reg.store_n;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  property p_hdr_read;
    i_ce && r_reg.start && r_reg.seq == SEQ7 && hdr_rise && r_reg.dir
      |=> r_reg.seq == SEQ6;
  endproperty
  a_hdr_read: assert property (p_hdr_read) else $error("no sequence 6");

  property p_seq6_quiet;
    r_reg.seq == SEQ6 |-> !o_read_gate && !o_bitclk_recovered;
  endproperty
  a_seq6_quiet: assert property (p_seq6_quiet) else $error("gate in 6");

  property p_skip_done;
    i_ce && r_reg.start && r_reg.seq == SEQ6 && sync_skip
      |=> r_reg.seq == SEQ4 && o_terminal_count;
  endproperty
  a_skip_done: assert property (p_skip_done) else $error("skip end");

  property p_seq4_gate;
    r_reg.seq == SEQ4 |-> o_read_gate && o_bitclk_recovered;
  endproperty
  a_seq4_gate: assert property (p_seq4_gate) else $error("gate in 4");

  property p_seq4_clear;
    r_reg.seq == SEQ4 |-> !o_count_run && r_reg.shreg == 8'h00;
  endproperty
  a_seq4_clear: assert property (p_seq4_clear) else $error("not clear");

  property p_detect;
    i_ce && r_reg.start && r_reg.seq == SEQ4 && bit_edge && data_det
      |=> r_reg.seq == SEQ5 && o_count_run;
  endproperty
  a_detect: assert property (p_detect) else $error("no sequence 5");

  property p_dir_gate;
    r_reg.seq == SEQ5 |-> o_write_gate == !r_reg.dir && o_read_gate == r_reg.dir;
  endproperty
  a_dir_gate: assert property (p_dir_gate) else $error("gate choice");

  property p_store;
    i_ce && strobe && r_reg.seq == SEQ5 && !wr_take ##1 i_ce && !wr_take
      |-> !o_mem_store_n ##1 o_mem_addr == $past(o_mem_addr) + 16'h1;
  endproperty
  a_store: assert property (p_store) else $error("store or step");

  property p_dec;
    i_ce && strobe && !wr_take && !len_zero |=> r_reg.len == $past(r_reg.len) - ONE;
  endproperty
  a_dec: assert property (p_dec) else $error("no decrement");

  property p_finish;
    i_ce && r_reg.start && r_reg.seq == SEQ2 && r_reg.settle == '0 && !r_reg.sf_done
      ##1 i_ce |-> o_sector_finished ##1 !o_sector_finished;
  endproperty
  a_finish: assert property (p_finish) else $error("finish pulse");

  property p_stop;
    i_ce && !r_reg.start |=> r_reg.seq == SEQ0;
  endproperty
  a_stop: assert property (p_stop) else $error("start low");

  c_seq5:  cover property (r_reg.seq == SEQ4 ##1 r_reg.seq == SEQ5);
  c_done:  cover property (o_sector_finished);
  c_fail:  cover property (!o_check_fail_flag_n && r_reg.seq == SEQ2);
  c_write: cover property (o_write_gate);
endmodule // sector_read_seq
`default_nettype wire

// [verif/read_channel_model.sv]
// behavioural read channel: recovered bit clock and serial read bits
`timescale 1ns/10ps
`default_nettype none
module read_channel_model
(
  input  wire logic i_read_gate,
  input  wire logic i_fill,
  output logic      o_recovered_bit_clock,
  output logic      o_serial_read_bits
);
  int         idx;
  logic [7:0] cur;
  // ---------------------------------------------------------------
  // bit stream
  // ---------------------------------------------------------------
  // bit time is 12 system clocks; the bit settles 40 ns before the rise
  // and holds 80 ns after it, well inside the synchroniser's margin
  initial
  begin
    o_recovered_bit_clock = 1'b0;
    o_serial_read_bits = 1'b0;
    forever
    begin
      @(posedge i_read_gate);
      idx = 0;
      while (i_read_gate)
      begin
        cur = i_fill ? 8'h10 + 8'((idx - 16) / 8) : 8'h00;
        o_serial_read_bits = (idx < 16) ? (idx == 15) : cur[7 - (idx - 16) % 8];
        #40 o_recovered_bit_clock = 1'b1;
        #40 o_recovered_bit_clock = 1'b0;
        #40 idx++;
      end
      // clock stands still; line no longer shows the last bit
      o_serial_read_bits = ~o_serial_read_bits;
    end
  end
endmodule // read_channel_model
`default_nettype wire

// [verif/sector_read_seq_tb.sv]
// self-checking bench of the sector read sequencer
`timescale 1ns/10ps
`default_nettype none
module sector_read_seq_tb;
  import sector_seq_pkg::*;
  localparam int L_CNT = 6;
  localparam int S_CNT = 9;
  localparam int C_CNT = 2;
  logic        clk, nrst, rd, wr, hdr, rbc, rbits, fill, bt, bt_q;
  logic        read_gate, write_gate, bitclk_rec, count_run, tc, sh_oe, hold_ld;
  logic        strobe, crc_rel, fail_n, sec_fin, store_n, waitreq;
  logic [7:0]  addr, byte_bus, mem_wdata;
  logic [15:0] mem_addr;
  logic [31:0] wdata, rdata, readdata;
  int          fail_count, comparisons, tc_n, sb_n, sf_n, ld_n, st_n;

  sector_read_seq #(.CNT_W(10), .XDIV(XTAL_DIV)) dut_u
  (
    .i_clk(clk), .i_nrst(nrst), .i_ce(1'b1), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(readdata), .o_avs_waitrequest(waitreq), .i_recovered_bit_clock(rbc),
    .i_serial_read_bits(rbits), .o_read_gate(read_gate), .o_write_gate(write_gate),
    .o_bitclk_recovered(bitclk_rec), .i_header_done_addr_bit(hdr), .o_count_run(count_run),
    .o_byte_tick(bt), .o_terminal_count(tc), .o_shifter_output_enable(sh_oe),
    .o_byte_bus(byte_bus), .o_holding_reg_load(hold_ld), .o_sequence_strobe(strobe),
    .o_crc_release(crc_rel), .o_check_fail_flag_n(fail_n), .o_sector_finished(sec_fin),
    .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata), .o_mem_store_n(store_n)
  );
  read_channel_model chan_u
  (
    .i_read_gate(read_gate), .i_fill(fill),
    .o_recovered_bit_clock(rbc), .o_serial_read_bits(rbits)
  );

  function automatic logic miss(input logic eq);
    comparisons++;
    return eq !== 1'b1;
  endfunction
  function automatic logic [7:0] exp_byte(input int k);
    return fill ? 8'h10 + 8'(k) : 8'h00;
  endfunction
  task automatic bad(input string m);
    fail_count++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // bus master and monitor
  // ---------------------------------------------------------------
  // sampling on the falling edge keeps every look race-free
  always @(negedge clk)
  begin
    bt_q <= bt;
    if (tc === 1'b1) tc_n++;
    if (strobe === 1'b1) sb_n++;
    if (sec_fin === 1'b1) sf_n++;
    if (hold_ld === 1'b1 && ld_n < L_CNT)
    begin
      if (miss(byte_bus === exp_byte(ld_n) && sh_oe === 1'b1 && bt_q === 1'b1))
        bad("byte bus");
      ld_n++;
    end
    if (store_n === 1'b0)
    begin
      if (miss(mem_wdata === exp_byte(st_n) && mem_addr === 16'h0040 + 16'(st_n))) bad("store");
      if (miss(crc_rel === (st_n + 1 >= C_CNT))) bad("crc release");
      st_n++;
    end
  end

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitreq !== 1'b0 && n < 40);
    rdata = readdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (miss(n < 40)) bad("bus hang");
  endtask
  task automatic header_pulse(input logic [31:0] ctrl);
    bus(1'b1, ADDR_CTRL, ctrl);
    @(posedge clk);
    hdr <= 1'b1;
    @(posedge clk);
    hdr <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic reset_values();
    if (miss(read_gate === 1'b0 && write_gate === 1'b0 && store_n === 1'b1)) bad("reset");
    bus(1'b0, ADDR_LEN, 32'h0);
    if (miss(rdata === 32'(LEN_LOAD - HDR_DEC))) bad("length load");
    bus(1'b0, ADDR_SETTLE, 32'h0);
    if (miss(rdata === 32'(SETTLE_LOAD - HDR_DEC))) bad("settle load");
    bus(1'b0, ADDR_CRCST, 32'h0);
    if (miss(rdata === 32'(CRCST_LOAD - HDR_DEC))) bad("crc start load");
    bus(1'b0, 8'h1C, 32'h0);
    if (miss(rdata === 32'h0)) bad("unmapped read");
    bus(1'b0, ADDR_STATUS, 32'h0);
    if (miss(rdata[7:0] === 8'h01 && fail_n === 1'b1)) bad("idle sequence");
  endtask

  // write direction raises the write gate but still stores deserialized bytes to RAM; there is no write path
  task automatic write_direction();
    header_pulse(32'h0000_0005);
    bus(1'b0, ADDR_STATUS, 32'h0);
    if (miss(rdata[7:0] === 8'h20 && rdata[ST_WRGATE] && !rdata[ST_RDGATE])) bad("wgate");
    bus(1'b1, ADDR_CTRL, 32'h0);
    bus(1'b0, ADDR_STATUS, 32'h0);
    if (miss(rdata[7:0] === 8'h01 && write_gate === 1'b0)) bad("start low");
  endtask

  task automatic sector(input logic f);
    int n;
    time t0;
    fill = f;
    tc_n = 0; sb_n = 0; sf_n = 0; ld_n = 0; st_n = 0;
    bus(1'b1, ADDR_LEN, 32'(L_CNT));
    bus(1'b1, ADDR_SETTLE, 32'(S_CNT));
    bus(1'b1, ADDR_CRCST, 32'(C_CNT));
    bus(1'b1, ADDR_MADDR, 32'h0000_0040);
    header_pulse(32'h0000_0007);
    t0 = $time;
    bus(1'b0, ADDR_STATUS, 32'h0);
    if (miss(rdata[7:0] === 8'h40 && rdata[ST_RDGATE] === 1'b0)) bad("sequence 6");
    for (n = 0; n < 1000 && read_gate !== 1'b1; n++) @(negedge clk);
    @(posedge clk);
    if (miss($time - t0 >= (SKIP_BITS - 1) * XTAL_DIV * 10)) bad("skip too short");
    if (miss($time - t0 <= (SKIP_BITS + 2) * XTAL_DIV * 10)) bad("skip too long");
    if (miss(bitclk_rec === 1'b1 && count_run === 1'b0 && tc_n === 1)) bad("seq 4");
    for (n = 0; n < 2000 && count_run !== 1'b1; n++) @(negedge clk);
    if (miss(read_gate === 1'b1 && write_gate === 1'b0 && n < 2000)) bad("seq 5");
    for (n = 0; n < 5000 && sf_n == 0; n++) @(negedge clk);
    if (miss(st_n === L_CNT && tc_n === 2)) bad("byte count");
    if (miss(sb_n === S_CNT && sf_n === 1)) bad("strobes");
    if (miss(fail_n === ~f)) bad("check flag");
    bus(1'b0, ADDR_STATUS, 32'h0);
    if (miss(rdata[7:0] === 8'h04 && count_run === 1'b1)) bad("sequence 2");
    bus(1'b1, ADDR_CTRL, 32'h0);
    bus(1'b0, ADDR_STATUS, 32'h0);
    if (miss(rdata[7:0] === 8'h01)) bad("back to idle");
  endtask

  // ---------------------------------------------------------------
  // run
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #200000;
    fail_count++;
    test_done();
  end
  initial
  begin
    nrst = 1'b0; rd = 1'b0; wr = 1'b0; hdr = 1'b0; fill = 1'b0;
    addr = 8'h00; wdata = 32'h0;
    fail_count = 0; comparisons = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    reset_values();
    write_direction();
    sector(1'b0);
    sector(1'b1);
    test_done();
  end
endmodule // sector_read_seq_tb
`default_nettype wire
